// ### verilog/pdsc_top.sv
// Purpose: register file and control of the two precision sense dividers
// Assumes: an external serial-to-wishbone bridge owns the pins; flag is asynchronous
// Notes:   index 0 of the per-divider outputs is divider a, index 1 divider b
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`include "pdsc_defines.svh"
module pdsc_top #(
  parameter logic [15:0] ID_VALUE = `PDSC_ID_VAL // arbitrary value
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // analog status
  input  wire logic                      flyback_overtemp_flag,
  // precision divider controls, [0] = a, [1] = b
  output logic      [1:0][3:0]           prec_div_ratio_sel,
  output logic      [1:0]                prec_div_hv_path_en,
  output logic      [1:0]                prec_div_force_zero,
  output logic      [1:0]                prec_div_powered,
  output logic      [1:0]                prec_div_buf_en,
  output logic      [1:0]                prec_div_lvl_shift_en,
  output logic      [1:0]                prec_div_int_sense_sel,
  // internal sense outputs
  output logic                           prec_sense_a_flag_out,
  output logic                           fast_sense_b_temp_sel,
  output logic      [1:0]                fast_div_out_mode
);
  import pdsc_pkg::*;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [5:0]  mode;
    logic [7:0]  cfg;
    logic        flag_out;
    logic        fast_temp;
  } pdsc_top_s;

  pdsc_top_s                 st_r;
  pdsc_top_s                 st_nxt;
  logic                      flag_sync;
  logic [`PDSC_IDX_W-1:0]    idx;
  logic                      req;
  logic [31:0]               rd_val;
  pdsc_ratio_t               ratio_f [2];
  pdsc_mode_t                mode_f  [2];
  logic                      en_n_f  [2];
  pdsc_div_state_e           div_st  [2];

  pdsc_sync2 u_flag_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (flyback_overtemp_flag),
    .q       (flag_sync)
  );

  // field split of the two configuration registers
  assign ratio_f[0] = st_r.cfg[`PDSC_CFG_A_RATIO_LSB +: 3];
  assign ratio_f[1] = st_r.cfg[`PDSC_CFG_B_RATIO_LSB +: 3];
  assign en_n_f[0]  = st_r.cfg[`PDSC_CFG_A_EN_N_BIT];
  assign en_n_f[1]  = st_r.cfg[`PDSC_CFG_B_EN_N_BIT];
  assign mode_f[0]  = st_r.mode[`PDSC_MODE_A_LSB +: 2];
  assign mode_f[1]  = st_r.mode[`PDSC_MODE_B_LSB +: 2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_div
      pdsc_div_ctrl u_div (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .ratio         (ratio_f[g]),
        .out_mode      (mode_f[g]),
        .enable_n      (en_n_f[g]),
        .state         (div_st[g]),
        .ratio_sel     (prec_div_ratio_sel[g]),
        .hv_path_en    (prec_div_hv_path_en[g]),
        .force_zero    (prec_div_force_zero[g]),
        .powered       (prec_div_powered[g]),
        .buf_en        (prec_div_buf_en[g]),
        .lvl_shift_en  (prec_div_lvl_shift_en[g]),
        .int_sense_sel (prec_div_int_sense_sel[g])
      );
    end
  endgenerate

  assign idx = wb_adr_i[7:2];
  assign req = wb_cyc_i && wb_stb_i;

  // read mux; unmapped indexes read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (idx)
      `PDSC_IDX_ID: begin
        rd_val[15:0] = ID_VALUE;
      end
      `PDSC_IDX_MODE: begin
        rd_val[5:0] = st_r.mode;
      end
      `PDSC_IDX_DIVCFG: begin
        rd_val[7:0] = st_r.cfg;
      end
      `PDSC_IDX_STATUS: begin
        rd_val[0] = flag_sync;
        rd_val[1] = (div_st[0] == PDSC_DIV_RUN);
        rd_val[2] = (div_st[0] == PDSC_DIV_ZERO);
        rd_val[3] = (div_st[0] == PDSC_DIV_OFF);
        rd_val[4] = (div_st[1] == PDSC_DIV_RUN);
        rd_val[5] = (div_st[1] == PDSC_DIV_ZERO);
        rd_val[6] = (div_st[1] == PDSC_DIV_OFF);
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    // fixed one-cycle answer: the port never stretches a transfer
    st_nxt.ack = req && !st_r.ack;
    st_nxt.dat = (req && !st_r.ack) ? rd_val : 32'h0000_0000;
    // write lands on the edge where the master sees ack
    if (req && st_r.ack && wb_we_i && wb_sel_i[0]) begin
      case (idx)
        `PDSC_IDX_MODE: begin
          st_nxt.mode = wb_dat_i[5:0];
        end
        `PDSC_IDX_DIVCFG: begin
          st_nxt.cfg = wb_dat_i[7:0];
        end
        default: begin
          st_nxt.mode = st_r.mode;
        end
      endcase
    end
    // flag only reaches pad a when the internal sense mode is picked
    st_nxt.flag_out  = (mode_f[0] == `PDSC_OM_INTERNAL) && flag_sync;
    st_nxt.fast_temp = (st_r.mode[`PDSC_MODE_FAST_LSB +: 2] == `PDSC_OM_INTERNAL);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // all zero: ratio /64, buffered level-shifted, both dividers enabled
      st_r      <= '0;
      st_r.mode <= `PDSC_MODE_RST;
      st_r.cfg  <= `PDSC_DIVCFG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o              = st_r.ack;
  assign wb_dat_o              = st_r.dat;
  assign prec_sense_a_flag_out = st_r.flag_out;
  assign fast_sense_b_temp_sel = st_r.fast_temp;
  assign fast_div_out_mode     = st_r.mode[`PDSC_MODE_FAST_LSB +: 2];

endmodule : pdsc_top

// ### verilog/pdsc_defines.svh
// Purpose: constants for the precision divider sense control block
// Assumes: register index times four gives the wishbone byte address
// Notes:   definitions only
`ifndef PDSC_DEFINES_SVH
`define PDSC_DEFINES_SVH

// register indexes (byte address = index * 4)
`define PDSC_IDX_W          6
`define PDSC_IDX_ID         6'h00
`define PDSC_IDX_MODE       6'h08
`define PDSC_IDX_DIVCFG     6'h09
`define PDSC_IDX_STATUS     6'h0A

// reset values
`define PDSC_MODE_RST       6'h00
`define PDSC_DIVCFG_RST     8'h00
`define PDSC_ID_VAL         16'h0000

// mode register fields
`define PDSC_MODE_FAST_LSB  0
`define PDSC_MODE_A_LSB     2
`define PDSC_MODE_B_LSB     4

// divider config register fields
`define PDSC_CFG_A_RATIO_LSB 0
`define PDSC_CFG_A_EN_N_BIT  3
`define PDSC_CFG_B_RATIO_LSB 4
`define PDSC_CFG_B_EN_N_BIT  7

// ratio codes
`define PDSC_RATIO_64       3'h0
`define PDSC_RATIO_32       3'h1
`define PDSC_RATIO_16       3'h2
`define PDSC_RATIO_8        3'h3
`define PDSC_RATIO_ZERO     3'h6
`define PDSC_RATIO_OFF      3'h7

// output mode codes
`define PDSC_OM_BUF_SHIFT   2'h0
`define PDSC_OM_UNBUF       2'h1
`define PDSC_OM_BUF         2'h2
`define PDSC_OM_INTERNAL    2'h3

`endif

// ### verilog/pdsc_pkg.sv
// Purpose: shared types of the precision divider sense control block
// Assumes: numeric constants live in pdsc_defines.svh
// Notes:   none
package pdsc_pkg;

  typedef enum logic [1:0] {
    PDSC_DIV_RUN,
    PDSC_DIV_ZERO,
    PDSC_DIV_OFF
  } pdsc_div_state_e;

  typedef logic [2:0] pdsc_ratio_t;
  typedef logic [1:0] pdsc_mode_t;

endpackage : pdsc_pkg

// ### verilog/pdsc_sync2.sv
// Purpose: two-flop synchroniser for one asynchronous level
// Assumes: d comes from outside the clk domain
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
module pdsc_sync2 (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // level
  input  wire logic d,
  output logic      q
);
  import pdsc_pkg::*;

  typedef struct packed {
    logic ff1;
    logic ff2;
  } pdsc_sync_s;

  pdsc_sync_s st_r;
  pdsc_sync_s st_nxt;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ff1 = d;
    st_nxt.ff2 = st_r.ff1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.ff2;

endmodule : pdsc_sync2

// ### verilog/pdsc_div_ctrl.sv
// Purpose: decode one precision divider's ratio, mode and enable into switch controls
// Assumes: inputs come from registers on clk
// Notes:   every output is a flop, one clock after the field changes
`timescale 1ns/10ps
`include "pdsc_defines.svh"
module pdsc_div_ctrl (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // fields
  input  wire pdsc_pkg::pdsc_ratio_t    ratio,
  input  wire pdsc_pkg::pdsc_mode_t     out_mode,
  input  wire logic                     enable_n,
  // controls
  output pdsc_pkg::pdsc_div_state_e     state,
  output logic [3:0]                    ratio_sel,
  output logic                          hv_path_en,
  output logic                          force_zero,
  output logic                          powered,
  output logic                          buf_en,
  output logic                          lvl_shift_en,
  output logic                          int_sense_sel
);
  import pdsc_pkg::*;

  typedef struct packed {
    pdsc_div_state_e st;
    logic [3:0]      sel;
    logic            path;
    logic            zero;
    logic            pwr;
    logic            buf_on;
    logic            shift;
    logic            intsel;
  } pdsc_div_s;

  pdsc_div_s st_r;
  pdsc_div_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    // unused codes 100/101 fall back to power-down, the safe side
    if (enable_n || ratio == `PDSC_RATIO_OFF || (ratio[2] && !ratio[1])) begin
      st_nxt.st = PDSC_DIV_OFF;
    end else if (ratio == `PDSC_RATIO_ZERO) begin
      st_nxt.st = PDSC_DIV_ZERO;
    end else begin
      st_nxt.st = PDSC_DIV_RUN;
    end
    st_nxt.sel = '0;
    case (st_nxt.st)
      PDSC_DIV_RUN: begin
        st_nxt.sel = 4'h1 << ratio[1:0];
      end
      PDSC_DIV_ZERO: begin
        st_nxt.sel = '0;
      end
      default: begin
        st_nxt.sel = '0;
      end
    endcase
    st_nxt.path   = (st_nxt.st == PDSC_DIV_RUN);
    st_nxt.zero   = (st_nxt.st == PDSC_DIV_ZERO);
    st_nxt.pwr    = (st_nxt.st != PDSC_DIV_OFF);
    st_nxt.buf_on = st_nxt.pwr && (out_mode == `PDSC_OM_BUF_SHIFT
                                   || out_mode == `PDSC_OM_BUF);
    st_nxt.shift  = st_nxt.pwr && (out_mode == `PDSC_OM_BUF_SHIFT);
    st_nxt.intsel = (out_mode == `PDSC_OM_INTERNAL);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign state         = st_r.st;
  assign ratio_sel     = st_r.sel;
  assign hv_path_en    = st_r.path;
  assign force_zero    = st_r.zero;
  assign powered       = st_r.pwr;
  assign buf_en        = st_r.buf_on;
  assign lvl_shift_en  = st_r.shift;
  assign int_sense_sel = st_r.intsel;

endmodule : pdsc_div_ctrl

// ### verification/pdsc_monitor.sv
// Purpose: port checker for pdsc_top
// Assumes: one clock, synchronous reset
// Notes:   bound to every pdsc_top
`timescale 1ns/10ps
module pdsc_monitor (
  // clock and reset
  input wire logic            clk,
  input wire logic            sys_rst,
  // bus
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic [31:0]     wb_dat_o,
  input wire logic            wb_ack_o,
  // status and controls
  input wire logic            flyback_overtemp_flag,
  input wire logic [1:0][3:0] prec_div_ratio_sel,
  input wire logic [1:0]      prec_div_hv_path_en,
  input wire logic [1:0]      prec_div_force_zero,
  input wire logic [1:0]      prec_div_powered,
  input wire logic [1:0]      prec_div_buf_en,
  input wire logic [1:0]      prec_div_lvl_shift_en,
  input wire logic [1:0]      prec_div_int_sense_sel,
  input wire logic            prec_sense_a_flag_out,
  input wire logic            fast_sense_b_temp_sel,
  input wire logic [1:0]      fast_div_out_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_ratio_hot: assert property ($onehot0(prec_div_ratio_sel[0])
      && $onehot0(prec_div_ratio_sel[1]))
    else $error("ratio select not one-hot");
  a_run_path: assert property (prec_div_hv_path_en
      == {|prec_div_ratio_sel[1], |prec_div_ratio_sel[0]})
    else $error("path state and ratio disagree");
  a_zero_open: assert property ((prec_div_force_zero & prec_div_hv_path_en) == 2'b00)
    else $error("force zero with path closed");
  a_off_quiet: assert property ((~prec_div_powered
      & (prec_div_hv_path_en | prec_div_buf_en)) == 2'b00)
    else $error("unpowered divider still active");
  a_buf_modes: assert property (((prec_div_lvl_shift_en & ~prec_div_buf_en)
      | (prec_div_int_sense_sel & prec_div_buf_en)) == 2'b00)
    else $error("buffer state wrong for mode");
  a_flag_delay: assert property (prec_sense_a_flag_out
      |-> $past(flyback_overtemp_flag, 3) && prec_div_int_sense_sel[0])
    else $error("flag output without cause");
  a_fast_temp: assert property (fast_sense_b_temp_sel
      == ($past(fast_div_out_mode) == 2'h3))
    else $error("fast temperature select wrong");
  c_zero: cover property (prec_div_force_zero[0]);
  c_flag: cover property (prec_sense_a_flag_out);
  c_temp: cover property (fast_sense_b_temp_sel);
endmodule : pdsc_monitor

bind pdsc_top pdsc_monitor i_mon (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .flyback_overtemp_flag, .prec_div_ratio_sel, .prec_div_hv_path_en,
  .prec_div_force_zero, .prec_div_powered, .prec_div_buf_en, .prec_div_lvl_shift_en,
  .prec_div_int_sense_sel, .prec_sense_a_flag_out, .fast_sense_b_temp_sel,
  .fast_div_out_mode);

// ### verification/pdsc_host.sv
// Purpose: host model issuing classic wishbone cycles
// Assumes: slave answers with ack
// Notes:   released lines show inverted data, not the last value
`timescale 1ns/10ps
module pdsc_host (
  // clock
  input  wire logic        clk,
  // master side
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat,
  input  wire logic        ack
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    dat = 32'h0000_0000;
  end
  // request held until ack sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    adr <= ~a;
    dat <= ~d;
  endtask : xfer
endmodule : pdsc_host

// ### verification/testbench.sv
// Purpose: self-checking bench for pdsc_top
// Assumes: host model drives the register bus
// Notes:   read results checked from a queue at ack
`timescale 1ns/10ps
module testbench;
  localparam logic [15:0] ID_ARB = 16'h5A3C; // arbitrary value
  logic            clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic            wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]      wb_adr_i;
  logic [3:0]      wb_sel_i;
  logic [31:0]     wb_dat_i, wb_dat_o;
  logic            flyback_overtemp_flag = 1'b0;
  logic [1:0][3:0] prec_div_ratio_sel;
  logic [1:0]      prec_div_hv_path_en, prec_div_force_zero, prec_div_powered;
  logic [1:0]      prec_div_buf_en, prec_div_lvl_shift_en, prec_div_int_sense_sel;
  logic            prec_sense_a_flag_out, fast_sense_b_temp_sel;
  logic [1:0]      fast_div_out_mode, md;
  logic [2:0]      rb;
  logic [31:0]     exp_q[$];
  int              fail_count = 0;
  int              total_checks = 0;

  always #5 clk = ~clk;

  pdsc_top #(.ID_VALUE(ID_ARB)) i_dut (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .flyback_overtemp_flag,
    .prec_div_ratio_sel, .prec_div_hv_path_en, .prec_div_force_zero, .prec_div_powered,
    .prec_div_buf_en, .prec_div_lvl_shift_en, .prec_div_int_sense_sel,
    .prec_sense_a_flag_out, .fast_sense_b_temp_sel, .fast_div_out_mode);
  pdsc_host i_host (.clk(clk), .cyc(wb_cyc_i), .stb(wb_stb_i), .we(wb_we_i),
    .adr(wb_adr_i), .sel(wb_sel_i), .dat(wb_dat_i), .ack(wb_ack_o));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_host.xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle
  function automatic logic [3:0] sel_of(input logic [2:0] c);
    sel_of = (c < 3'h4) ? 4'h1 << c : 4'h0;
  endfunction : sel_of

  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      chk(wb_dat_o, exp_q.pop_front());
    end
  end

  initial begin
    #60000;
    fail_count++;
    stop_test();
  end

  initial begin
    void'($urandom(32'hd222185a));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    chk(prec_div_ratio_sel, 8'h11);
    chk(prec_div_hv_path_en, 2'b11);
    rd(8'h20, 32'h0000_0000);
    rd(8'h24, 32'h0000_0000);
    rd(8'h00, {16'h0000, ID_ARB});
    $display("reset test done");
    for (int c = 0; c < 8; c++) begin
      if (c == 4 || c == 5) continue;
      rb = 3'($urandom_range(3));
      i_host.xfer(1'b1, 8'h24, {24'h0, 1'b0, rb, 1'b0, 3'(c)});
      settle();
      chk(prec_div_ratio_sel[0], sel_of(3'(c)));
      chk(prec_div_ratio_sel[1], sel_of(rb));
      chk(prec_div_force_zero[0], c == 6);
      chk(prec_div_hv_path_en[0], c < 4);
      rd(8'h24, {24'h0, 1'b0, rb, 1'b0, 3'(c)});
    end
    i_host.xfer(1'b1, 8'h24, 32'h0000_0088);
    settle();
    chk(prec_div_hv_path_en, 2'b00);
    chk(prec_div_powered, 2'b00);
    i_host.xfer(1'b1, 8'h24, 32'h0000_0000);
    $display("ratio test done");
    for (int m = 0; m < 4; m++) begin
      md = 2'(m);
      i_host.xfer(1'b1, 8'h20, {26'h0, md, md, ~md});
      settle();
      chk(prec_div_buf_en, {2{md == 2'h0 || md == 2'h2}});
      chk(prec_div_lvl_shift_en, {2{md == 2'h0}});
      chk(prec_div_int_sense_sel, {2{md == 2'h3}});
      chk(fast_div_out_mode, 2'(~md));
      chk(fast_sense_b_temp_sel, md == 2'h0);
    end
    $display("mode test done");
    @(posedge clk);
    flyback_overtemp_flag <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(prec_sense_a_flag_out, 1'b0);
    settle();
    chk(prec_sense_a_flag_out, 1'b1);
    rd(8'h28, 32'h0000_0013);
    flyback_overtemp_flag <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(prec_sense_a_flag_out, 1'b0);
    // pad a leaves internal sense: a raised flag must not reach it
    i_host.xfer(1'b1, 8'h20, 32'h0000_0034);
    flyback_overtemp_flag <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(prec_sense_a_flag_out, 1'b0);
    chk(prec_div_int_sense_sel, 2'b10);
    $display("flag test done");
    @(posedge clk);
    flyback_overtemp_flag <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    chk(prec_div_int_sense_sel, 2'b00);
    chk(prec_div_buf_en, 2'b11);
    chk(prec_div_ratio_sel, 8'h11);
    rd(8'h20, 32'h0000_0000);
    rd(8'h28, 32'h0000_0012);
    $display("second reset test done");
    i_host.xfer(1'b1, 8'hFC, $urandom);
    rd(8'hFC, 32'h0000_0000);
    i_host.xfer(1'b1, 8'h00, $urandom);
    rd(8'h00, {16'h0000, ID_ARB});
    $display("map test done");
    stop_test();
  end
endmodule : testbench
